// ---- common/sarg_pkg.sv ----
// Purpose: Constants for the serial port negotiation ability register slice
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Printed offsets are not word multiples, so byte address is four times the index
package sarg_pkg;
	// Register indices and the derived byte addresses
	localparam logic [23:0] sarg_idx_port_id = 24'h1f0003;
	localparam logic [23:0] sarg_idx_advert = 24'h1f0004;
	localparam logic [23:0] sarg_idx_partner = 24'h1f0005;
	localparam logic [23:0] sarg_idx_neg_ctrl = 24'h1f8001;
	localparam logic [23:0] sarg_idx_neg_stat = 24'h1f8002;
	localparam logic [25:0] sarg_addr_port_id = {sarg_idx_port_id, 2'b00};
	localparam logic [25:0] sarg_addr_advert = {sarg_idx_advert, 2'b00};
	localparam logic [25:0] sarg_addr_partner = {sarg_idx_partner, 2'b00};
	localparam logic [25:0] sarg_addr_neg_ctrl = {sarg_idx_neg_ctrl, 2'b00};
	localparam logic [25:0] sarg_addr_neg_stat = {sarg_idx_neg_stat, 2'b00};
	// Advertisement and partner field positions
	localparam int sarg_bit_next_page = 15;
	localparam int sarg_bit_ack = 14;
	localparam int sarg_fault_hi = 13;
	localparam int sarg_fault_lo = 12;
	localparam int sarg_pause_hi = 8;
	localparam int sarg_pause_lo = 7;
	localparam int sarg_bit_half = 6;
	localparam int sarg_bit_full = 5;
	// Writable bits of the advertisement word, and the bits kept from a partner page
	localparam logic [15:0] sarg_advert_wmask = 16'h31e0;
	localparam logic [15:0] sarg_partner_mask = 16'hf1e0;
	// Reset values
	localparam logic [15:0] sarg_advert_reset = 16'h0020;
	localparam logic [15:0] sarg_partner_reset = 16'h0000;
	// Arbitrary value, not tied to any real part
	localparam logic [15:0] sarg_port_id_low = 16'h5a01;
	// Negotiation control: mode field at bits 2:1
	localparam int sarg_mode_hi = 2;
	localparam int sarg_mode_lo = 1;
	localparam logic [1:0] sarg_mode_serdes = 2'h0;
	localparam logic [1:0] sarg_mode_sgmii = 2'h2;
	localparam logic [15:0] sarg_ctrl_wmask = 16'h001e;
	localparam logic [15:0] sarg_ctrl_reset = 16'h0004;
	localparam int sarg_bit_complete = 0;
	typedef enum logic [2:0]
	{
		sarg_st_idle = 3'b001,
		sarg_st_setup = 3'b010,
		sarg_st_done = 3'b100
	} sarg_apb_e;
endpackage : sarg_pkg

// ---- core/sarg_regs.sv ----
// Purpose: Port identifier, local advertisement and partner ability registers over APB
// Assumes: Page capture and completion come from the negotiation engine beside this block
// Notes: Answers every transfer with two wait states; unmapped reads return zero
`timescale 1ns/1ns
`default_nettype none
module sarg_regs
	import sarg_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Negotiation engine side
	input wire logic page_valid,
	input wire logic [15:0] page_word,
	input wire logic ack_exchanged,
	input wire logic restart_neg,
	output logic [15:0] tx_codeword,
	output logic [15:0] neg_ctrl_active,
	output logic serdes_mode,
	output logic neg_complete
);
	sarg_apb_e state;
	logic [15:0] advert;
	logic [15:0] partner;
	logic [15:0] ctrl_pending;
	logic [15:0] ctrl_live;
	logic complete;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] next_rdata;
	logic next_err;

	// Decode the byte address into a read value; unmapped gives zero and an error
	function automatic logic [32:0] sarg_read(input logic [31:0] a, input logic [15:0] adv,
		input logic [15:0] lp, input logic [15:0] cp, input logic cmp);
		logic [32:0] r;
		r = 33'h0;
		if (a[31:26] != 6'h00)
			r = {1'b1, 32'h00000000};
		else if (a[25:0] == sarg_addr_port_id)
			r = {1'b0, 16'h0000, sarg_port_id_low};
		else if (a[25:0] == sarg_addr_advert)
			r = {1'b0, 16'h0000, adv & sarg_advert_wmask};
		else if (a[25:0] == sarg_addr_partner)
			r = {1'b0, 16'h0000, lp & sarg_partner_mask};
		else if (a[25:0] == sarg_addr_neg_ctrl)
			r = {1'b0, 16'h0000, cp & sarg_ctrl_wmask};
		else if (a[25:0] == sarg_addr_neg_stat)
			r = {1'b0, 31'h00000000, cmp};
		else
			r = {1'b1, 32'h00000000};
		return r;
	endfunction : sarg_read

	// Access phase takes two wait states; data are registered at the same edge that raises pready
	assign wr_fire = psel && penable && pwrite && (state == sarg_st_setup);
	assign rd_fire = psel && penable && !pwrite && (state == sarg_st_setup);

	always_comb
	begin
		{next_err, next_rdata} = sarg_read(paddr, advert, partner, ctrl_pending, complete);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= sarg_st_idle;
		else
			case (state)
				sarg_st_idle:
					if (psel && penable)
						state <= sarg_st_setup;
				sarg_st_setup:
					state <= sarg_st_done;
				sarg_st_done:
					state <= sarg_st_idle;
				default:
					state <= sarg_st_idle;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= (state == sarg_st_setup);
			pslverr <= (state == sarg_st_setup) && next_err;
			prdata <= rd_fire ? next_rdata : 32'h00000000;
		end
	end

	// Bus answer: one-cycle pready, data and error only alongside it
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held longer than one cycle");
	err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h00000000)
		else $error("read data outside the answer cycle");
	write_rdata_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire |=> prdata == 32'h00000000)
		else $error("read data driven on a write");
	high_addr_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_fire || rd_fire) && paddr[31:26] != 6'h00 |=> pslverr && pready)
		else $error("out of range address not refused");
	read_advert_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fire && paddr == {6'h00, sarg_addr_advert}
		|=> prdata == {16'h0000, $past(advert)} && !prdata[sarg_bit_next_page])
		else $error("advertisement read wrong");
	read_partner_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fire && paddr == {6'h00, sarg_addr_partner}
		|=> prdata == {16'h0000, $past(partner)} && (prdata[15:0] & ~sarg_partner_mask) == 16'h0000)
		else $error("partner read wrong");
	read_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fire && paddr == {6'h00, sarg_addr_neg_ctrl}
		|=> prdata == {16'h0000, $past(ctrl_pending)})
		else $error("pending control read wrong");
	read_status_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fire && paddr == {6'h00, sarg_addr_neg_stat}
		|=> prdata == {31'h00000000, $past(complete)})
		else $error("completion status read wrong");
	state_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot(state))
		else $error("bus state not one-hot");

	// Only the fault, pause and duplex bits take writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			advert <= sarg_advert_reset;
		else if (wr_fire && paddr[31:0] == {6'h00, sarg_addr_advert})
			advert <= pwdata[15:0] & sarg_advert_wmask;
	end

	ro_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && paddr == {6'h00, sarg_addr_port_id}
		|=> $stable(advert) && $stable(ctrl_pending))
		else $error("read-only register write changed state");

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_pending <= sarg_ctrl_reset;
		else if (wr_fire && paddr[31:0] == {6'h00, sarg_addr_neg_ctrl})
			ctrl_pending <= pwdata[15:0] & sarg_ctrl_wmask;
	end

	pending_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && paddr == {6'h00, sarg_addr_neg_ctrl}
		|=> ctrl_pending == ($past(pwdata[15:0]) & sarg_ctrl_wmask))
		else $error("control write not held pending");
	pending_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_fire && paddr == {6'h00, sarg_addr_neg_ctrl}) |=> $stable(ctrl_pending))
		else $error("pending control changed without a write");

	// Pending control goes live only on an advertisement write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_live <= sarg_ctrl_reset;
		else if (wr_fire && paddr[31:0] == {6'h00, sarg_addr_advert})
			ctrl_live <= ctrl_pending;
	end

	commit_take_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && paddr == {6'h00, sarg_addr_advert}
		|=> ctrl_live == $past(ctrl_pending))
		else $error("pending control not applied on advertisement write");

	// A half-received page never disturbs the held word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			partner <= sarg_partner_reset;
		else if (page_valid)
			partner <= page_word & sarg_partner_mask;
	end

	partner_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
		page_valid |=> partner[sarg_bit_ack] == $past(page_word[sarg_bit_ack]))
		else $error("partner acknowledge bit not captured");
	partner_np_a: assert property (@(posedge pclk) disable iff (!presetn)
		page_valid |=> partner[sarg_bit_next_page] == $past(page_word[sarg_bit_next_page]))
		else $error("partner next page bit not captured");

	// Set wins over a restart in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			complete <= 1'b0;
		else if (ack_exchanged)
			complete <= 1'b1;
		else if (restart_neg)
			complete <= 1'b0;
	end

	restart_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		restart_neg && !ack_exchanged |=> !complete)
		else $error("restart did not clear completion");
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		ack_exchanged |=> complete)
		else $error("completion not set by acknowledge exchange");

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_codeword <= 16'h0000;
			neg_ctrl_active <= sarg_ctrl_reset;
			serdes_mode <= 1'b0;
			neg_complete <= 1'b0;
		end
		else
		begin
			serdes_mode <= (ctrl_live[sarg_mode_hi:sarg_mode_lo] == sarg_mode_serdes);
			tx_codeword <= (ctrl_live[sarg_mode_hi:sarg_mode_lo] == sarg_mode_serdes)
				? (advert & sarg_advert_wmask) : 16'h0000;
			neg_ctrl_active <= ctrl_live;
			neg_complete <= complete;
		end
	end

	// Committed control reaches the engine one cycle later
	sgmii_tx_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_live[sarg_mode_hi:sarg_mode_lo] != sarg_mode_serdes
		|=> tx_codeword == 16'h0000)
		else $error("codeword sent outside SerDes mode");
	serdes_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_live[sarg_mode_hi:sarg_mode_lo] == sarg_mode_sgmii |=> !serdes_mode)
		else $error("SGMII mode flagged as SerDes");
	serdes_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_live[sarg_mode_hi:sarg_mode_lo] == sarg_mode_serdes |=> serdes_mode)
		else $error("SerDes mode not flagged");
	ctrl_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> neg_ctrl_active == $past(ctrl_live))
		else $error("committed control not presented");
	complete_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> neg_complete == $past(complete))
		else $error("completion flag not presented");

	// Assertions
	next_page_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		!advert[sarg_bit_next_page] && !tx_codeword[sarg_bit_next_page])
		else $error("local next page bit is set");
	advert_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_fire && paddr == {6'h00, sarg_addr_advert}
		|=> advert == ($past(pwdata[15:0]) & sarg_advert_wmask))
		else $error("advertisement write not stored");
	advert_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_fire && paddr == {6'h00, sarg_addr_advert}) |=> $stable(advert))
		else $error("advertisement changed without a write");
	ctrl_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_fire && paddr == {6'h00, sarg_addr_advert}) |=> $stable(ctrl_live))
		else $error("control applied without advertisement write");
	tx_codeword_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_live[sarg_mode_hi:sarg_mode_lo] == sarg_mode_serdes
		|=> tx_codeword == ($past(advert) & sarg_advert_wmask))
		else $error("codeword does not follow advertisement");
	partner_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		page_valid |=> partner == ($past(page_word) & sarg_partner_mask))
		else $error("partner page not captured");
	partner_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!page_valid |=> $stable(partner))
		else $error("partner word changed without a page");
	complete_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		ack_exchanged |-> ##2 neg_complete)
		else $error("completion flag not raised");
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready && state == sarg_st_idle |-> ##2 pready)
		else $error("apb answer late");
	port_id_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fire && paddr == {6'h00, sarg_addr_port_id}
		|=> prdata == {16'h0000, sarg_port_id_low})
		else $error("port identifier read wrong");
endmodule : sarg_regs
`default_nettype wire

// ---- tb/sarg_partner.sv ----
// Purpose: Negotiation engine stand-in that feeds pages and handshakes
// Assumes: Each pulse lasts one pclk cycle
// Notes: An idle page bus shows the inverse of the last page
`timescale 1ns/1ns
`default_nettype none
module sarg_partner
(
	// Clock
	input wire logic pclk,
	// Engine pulses
	output logic page_valid,
	output logic [15:0] page_word,
	output logic ack_exchanged,
	output logic restart_neg
);
	initial
	begin
		page_valid = 1'b0;
		page_word = 16'hffff;
		ack_exchanged = 1'b0;
		restart_neg = 1'b0;
	end
	task automatic pulse(input logic [1:0] kind, input logic [15:0] w);
	begin
		@(posedge pclk);
		page_word <= w;
		page_valid <= (kind == 2'h0);
		// Kind 3 raises both so the set-over-restart priority gets exercised
		ack_exchanged <= kind[0];
		restart_neg <= kind[1];
		@(posedge pclk);
		page_valid <= 1'b0;
		ack_exchanged <= 1'b0;
		restart_neg <= 1'b0;
		page_word <= ~w;
	end
	endtask : pulse
endmodule : sarg_partner
`default_nettype wire

// ---- tb/sarg_regs_tb_top.sv ----
// Purpose: Self-checking bench for the ability register slice
// Assumes: One APB master here, engine pulses from sarg_partner
// Notes: Expected words are kept in plain model variables
`timescale 1ns/1ns
`default_nettype none
module sarg_regs_tb_top import sarg_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd, seed, d, m_adv, m_part;
	logic page_valid, ack_exchanged, restart_neg, serdes_mode, neg_complete;
	logic [15:0] page_word, tx_codeword, neg_ctrl_active;
	int bad_count = 0, checked = 0, cycles = 0, i;
	sarg_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .page_valid(page_valid), .page_word(page_word),
		.ack_exchanged(ack_exchanged), .restart_neg(restart_neg), .tx_codeword(tx_codeword),
		.neg_ctrl_active(neg_ctrl_active), .serdes_mode(serdes_mode),
		.neg_complete(neg_complete));
	sarg_partner i_partner (.pclk(pclk), .page_valid(page_valid), .page_word(page_word),
		.ack_exchanged(ack_exchanged), .restart_neg(restart_neg));
	function logic [31:0] next_rand();
	begin
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	end
	endfunction : next_rand
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask : chk
	// Holds the request until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [25:0] a, input logic [31:0] dw);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= 32'(a);
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask : apb
	task automatic rdc(input logic [25:0] a, input logic [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	end
	endtask : rdc
	task conclude();
	begin
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask : conclude
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			conclude();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		seed = 32'h5935;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(neg_ctrl_active), 32'h4);
		chk(32'(tx_codeword), 32'h0);
		chk(32'(serdes_mode), 32'h0);
		rdc(sarg_addr_port_id, 32'(sarg_port_id_low));
		rdc(sarg_addr_advert, 32'h20);
		rdc(sarg_addr_partner, 32'h0);
		$display("reset values done");
		apb(1'b1, sarg_addr_neg_ctrl, 32'h18);
		chk(32'(neg_ctrl_active), 32'h4);
		rdc(sarg_addr_neg_ctrl, 32'h18);
		for (i = 0; i < 4; i++)
		begin
			d = next_rand() | 32'h8000;
			d[13:12] = 2'(i);
			d[8:7] = 2'(3 - i);
			apb(1'b1, sarg_addr_advert, d);
			m_adv = d & 32'h31e0;
			@(posedge pclk);
			chk(32'(neg_ctrl_active), 32'h18);
			chk(32'(serdes_mode), 32'h1);
			chk(32'(tx_codeword), m_adv);
			rdc(sarg_addr_advert, m_adv);
		end
		// Reserved, then SGMII, then back to SerDes so partner reads stay meaningful
		for (i = 1; i < 4; i++)
		begin
			d = 32'h18 | (32'(i % 3) << 1);
			apb(1'b1, sarg_addr_neg_ctrl, d);
			apb(1'b1, sarg_addr_advert, m_adv);
			@(posedge pclk);
			chk(32'(neg_ctrl_active), d);
			chk(32'(serdes_mode), 32'(i == 3));
			chk(32'(tx_codeword), (i == 3) ? m_adv : 32'h0);
		end
		$display("advertisement done");
		apb(1'b1, sarg_addr_port_id, 32'hffff);
		rdc(sarg_addr_port_id, 32'(sarg_port_id_low));
		apb(1'b1, 26'h40, 32'hffff);
		chk(32'(err), 32'h1);
		rdc(26'h40, 32'h0);
		chk(32'(err), 32'h1);
		$display("refusals done");
		d = next_rand() | 32'h8000;
		i_partner.pulse(2'h0, d[15:0]);
		m_part = d & 32'hf1e0;
		rdc(sarg_addr_partner, m_part);
		repeat (3) @(posedge pclk);
		rdc(sarg_addr_partner, m_part);
		i_partner.pulse(2'h1, 16'h0);
		rdc(sarg_addr_neg_stat, 32'h1);
		chk(32'(neg_complete), 32'h1);
		i_partner.pulse(2'h2, 16'h0);
		repeat (2) @(posedge pclk);
		chk(32'(neg_complete), 32'h0);
		i_partner.pulse(2'h3, 16'h0);
		repeat (2) @(posedge pclk);
		chk(32'(neg_complete), 32'h1);
		$display("partner page done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(serdes_mode), 32'h0);
		chk(32'(neg_complete), 32'h0);
		chk(32'(neg_ctrl_active), 32'h4);
		chk(32'(tx_codeword), 32'h0);
		rdc(sarg_addr_advert, 32'h20);
		rdc(sarg_addr_partner, 32'h0);
		rdc(sarg_addr_neg_ctrl, 32'h4);
		$display("reset again done");
		conclude();
	end
endmodule : sarg_regs_tb_top
`default_nettype wire
